// [verilog/tsi_pkg.sv]
// Constants and types for the transmit line state injector.
package tsi_pkg;

    // ==========================================================================
    // Timing.
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned PAIR_PERIOD_NS = 80;
    localparam int unsigned PAIR_CYCLES    = (PAIR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W          = 4;
    localparam logic [DIV_W-1:0] PAIR_LAST = DIV_W'(PAIR_CYCLES - 1);

    // ==========================================================================
    // Register map and fields.
    localparam logic [7:0] ADDR_TSC  = 8'h04;
    localparam logic [7:0] ADDR_THR  = 8'h05;
    localparam logic [7:0] ADDR_SYMA = 8'h06;
    localparam logic [7:0] ADDR_SYMB = 8'h07;
    localparam logic [7:0] TSC_RESET = 8'ha2;
    localparam int TM_LSB  = 0;
    localparam int TM_MSB  = 2;
    localparam int IC0_BIT = 3;
    localparam int IC1_BIT = 4;
    localparam int SE_BIT  = 5;
    localparam int PE_BIT  = 6;
    localparam int SYM_W   = 5;

    localparam logic [2:0] TM_ACTIVE = 3'h0;
    localparam logic [2:0] TM_IDLE   = 3'h1;
    localparam logic [2:0] TM_OFF    = 3'h2;
    localparam logic [2:0] TM_MASTER = 3'h4;
    localparam logic [2:0] TM_HALT   = 3'h5;
    localparam logic [2:0] TM_QUIET  = 3'h6;

    localparam logic [1:0] IC_NONE     = 2'h0;
    localparam logic [1:0] IC_ONESHOT  = 2'h1;
    localparam logic [1:0] IC_PERIODIC = 2'h2;
    localparam logic [1:0] IC_CONT     = 2'h3;

    // ==========================================================================
    // Line symbols.
    localparam logic [SYM_W-1:0] SYM_IDLE  = 5'h1f;
    localparam logic [SYM_W-1:0] SYM_QUIET = 5'h00;
    localparam logic [SYM_W-1:0] SYM_HALT  = 5'h04;
    localparam logic [SYM_W-1:0] SYM_J     = 5'h18;
    localparam logic [SYM_W-1:0] SYM_K     = 5'h11;

    // ==========================================================================
    // Types.
    typedef struct packed {
        logic [SYM_W-1:0] first;
        logic [SYM_W-1:0] second;
    } tsi_pair_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsi_cbus_req_t;

    typedef struct packed {
        tsi_pair_t pair;
        logic      en;
        logic      strobe;
    } tsi_tx_t;

    typedef enum logic [1:0] {
        OS_WAIT  = 2'b01,
        OS_ARMED = 2'b10
    } tsi_os_t;

    typedef struct packed {
        logic [7:0]       tsc;
        logic [7:0]       thr;
        logic [SYM_W-1:0] sym_a;
        logic [SYM_W-1:0] sym_b;
        logic [7:0]       cnt;
        tsi_os_t          os;
        logic [DIV_W-1:0] div;
        tsi_tx_t          tx;
        logic [7:0]       rdata;
        logic             wr_reject;
        logic [2:0]       trig_sync;
        logic             trig_lvl;
        logic             copy_busy;
    } tsi_state_t;

    localparam tsi_state_t STATE_RESET = '{tsc: TSC_RESET, thr: '0, sym_a: '0, sym_b: '0, cnt: '0,
                                           os: OS_WAIT, div: '0, tx: '0, rdata: '0, wr_reject: 1'b0,
                                           trig_sync: '0, trig_lvl: 1'b0, copy_busy: 1'b0};

endpackage

// [verilog/tsi_injector.sv]
// Transmit symbol pair selector with request FIFO, line state generator and injector.
`timescale 1ns/10ps

// ==============================================================================
// Request data FIFO.
module tsi_fifo #(
    parameter int unsigned W = 10,
    parameter int unsigned D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int unsigned AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                rdy;
    } tsi_fifo_state_t;

    localparam tsi_fifo_state_t FIFO_RESET = '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};

    tsi_fifo_state_t s;
    tsi_fifo_state_t n;
    logic            push;
    logic            pop;

    function automatic logic [AW-1:0] tsi_next_ptr(input logic [AW-1:0] p);
        tsi_next_ptr = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = s.rdy;
    assign out_valid = (s.cnt != '0);
    assign out_data  = s.mem[s.rp];

    always_comb begin
        n    = s;
        push = in_valid && s.rdy;
        pop  = out_ready && (s.cnt != '0);
        if (push) begin
            n.mem[s.wp] = in_data;
            n.wp        = tsi_next_ptr(s.wp);
        end
        if (pop) begin
            n.rp = tsi_next_ptr(s.rp);
        end
        n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        n.rdy = (n.cnt != (AW + 1)'(D));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= FIFO_RESET;
        end else if (ce) begin
            s <= n;
        end
    end
endmodule

// ==============================================================================
// Transmit state control and symbol pair selection.
module tsi_injector #(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   ce,
    input  wire tsi_pkg::tsi_cbus_req_t cb,
    output logic [7:0]                  cb_rdata,
    output logic                        cb_write_reject,
    input  wire logic                   req_valid,
    input  wire tsi_pkg::tsi_pair_t     req_pair,
    output logic                        req_ready,
    input  wire logic                   trigger_pin,
    input  wire logic                   trigger_react_en,
    input  wire logic [2:0]             trigger_tx_mode,
    input  wire logic                   stop_mode,
    output tsi_pkg::tsi_tx_t            tx,
    output logic                        smoother_en,
    output logic                        req_parity_en
);
    import tsi_pkg::*;

    tsi_state_t s;
    tsi_state_t n;
    logic       tick;
    logic       pop;
    logic       is_jk;
    logic       inj;
    logic       tsc_wr;
    logic       thr_wr;
    logic       fifo_valid;
    tsi_pair_t  fifo_data;
    tsi_pair_t  base;
    logic       base_en;
    logic [2:0] tm;
    logic [1:0] ic;

    function automatic tsi_pair_t tsi_mk_pair(input logic [SYM_W-1:0] a, input logic [SYM_W-1:0] b);
        tsi_mk_pair = '{first: a, second: b};
    endfunction

    // ==========================================================================
    // Request data buffer.
    tsi_fifo #(
        .W ($bits(tsi_pair_t)),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .in_valid  (req_valid),
        .in_data   (req_pair),
        .in_ready  (req_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    assign tx              = s.tx;
    assign cb_rdata        = s.rdata;
    assign cb_write_reject = s.wr_reject;
    assign smoother_en     = s.tsc[SE_BIT];
    assign req_parity_en   = s.tsc[PE_BIT];

    assign tick   = (s.div == PAIR_LAST);
    assign tm     = s.tsc[TM_MSB:TM_LSB];
    assign ic     = {s.tsc[IC1_BIT], s.tsc[IC0_BIT]};
    assign tsc_wr = cb.wr && (cb.addr == ADDR_TSC);
    assign thr_wr = cb.wr && (cb.addr == ADDR_THR);

    // ==========================================================================
    // Next state.
    always_comb begin
        n           = s;
        n.wr_reject = 1'b0;
        n.tx.strobe = 1'b0;
        n.copy_busy = 1'b0;
        inj         = 1'b0;
        base        = tsi_mk_pair(SYM_QUIET, SYM_QUIET);
        base_en     = s.tx.en;
        pop         = 1'b0;
        is_jk       = 1'b0;

        // Trigger pin filter: a level counts once the last two stages agree.
        n.trig_sync = {s.trig_sync[1:0], trigger_pin};
        if (s.trig_sync[1] == s.trig_sync[2]) begin
            n.trig_lvl = s.trig_sync[2];
        end
        if (!s.trig_lvl && n.trig_lvl && trigger_react_en) begin
            n.copy_busy = 1'b1;
        end
        if (s.copy_busy) begin
            n.tsc[TM_MSB:TM_LSB] = trigger_tx_mode;
        end

        // Pair timing; everything in the tick branch below happens once per pair period.
        n.div = tick ? '0 : DIV_W'(s.div + 1'b1);
        if (tick) begin
            n.tx.strobe = 1'b1;
            pop         = (tm == TM_ACTIVE) && fifo_valid && !stop_mode;
            is_jk       = pop && (fifo_data == tsi_mk_pair(SYM_J, SYM_K));
            case (tm)
                TM_ACTIVE: begin
                    base    = pop ? fifo_data : tsi_mk_pair(SYM_IDLE, SYM_IDLE);
                    base_en = 1'b1;
                end
                TM_IDLE: begin
                    base    = tsi_mk_pair(SYM_IDLE, SYM_IDLE);
                    base_en = 1'b1;
                end
                TM_OFF: begin
                    base    = tsi_mk_pair(SYM_QUIET, SYM_QUIET);
                    base_en = 1'b0;
                end
                TM_MASTER: begin
                    base    = tsi_mk_pair(SYM_HALT, SYM_QUIET);
                    base_en = 1'b1;
                end
                TM_HALT: begin
                    base    = tsi_mk_pair(SYM_HALT, SYM_HALT);
                    base_en = 1'b1;
                end
                TM_QUIET: begin
                    base = tsi_mk_pair(SYM_QUIET, SYM_QUIET);
                end
                default: begin
                    base = tsi_mk_pair(SYM_QUIET, SYM_QUIET);
                end
            endcase

            if (!stop_mode) begin
                case (ic)
                    IC_ONESHOT: begin
                        case (s.os)
                            OS_WAIT: begin
                                if (is_jk && (s.thr == '0)) begin
                                    inj              = 1'b1;
                                    n.tsc[IC0_BIT]   = 1'b0;
                                end else if (is_jk) begin
                                    n.cnt = s.thr;
                                    n.os  = OS_ARMED;
                                end
                            end
                            OS_ARMED: begin
                                if (s.cnt <= 8'h01) begin
                                    inj            = 1'b1;
                                    n.tsc[IC0_BIT] = 1'b0;
                                    n.cnt          = s.thr;
                                    n.os           = OS_WAIT;
                                end else begin
                                    n.cnt = s.cnt - 8'h01;
                                end
                            end
                            default: begin
                                n.os = OS_WAIT;
                            end
                        endcase
                    end
                    IC_PERIODIC: begin
                        n.os = OS_WAIT;
                        if (s.cnt <= 8'h01) begin
                            inj   = 1'b1;
                            n.cnt = s.thr;
                        end else begin
                            n.cnt = s.cnt - 8'h01;
                        end
                    end
                    IC_CONT: begin
                        n.os = OS_WAIT;
                        inj  = 1'b1;
                    end
                    default: begin
                        n.os = OS_WAIT;
                    end
                endcase
            end

            // Injection over mode, mode over data; stop mode ignores the register.
            if (stop_mode) begin
                n.tx.pair = tsi_mk_pair(SYM_QUIET, SYM_QUIET);
                n.tx.en   = 1'b0;
            end else begin
                n.tx.pair = inj ? tsi_mk_pair(s.sym_a, s.sym_b) : base;
                n.tx.en   = base_en;
            end
        end

        // Register writes; a software write overrides the hardware clear of the same cycle.
        if (tsc_wr && (s.copy_busy || n.copy_busy)) begin
            n.wr_reject = 1'b1;
        end else if (tsc_wr) begin
            n.tsc = cb.wdata;
        end
        if (thr_wr) begin
            n.thr = cb.wdata;
            n.cnt = cb.wdata;
        end
        if (cb.wr && (cb.addr == ADDR_SYMA)) begin
            n.sym_a = cb.wdata[SYM_W-1:0];
        end
        if (cb.wr && (cb.addr == ADDR_SYMB)) begin
            n.sym_b = cb.wdata[SYM_W-1:0];
        end

        // Register reads; unmapped addresses read as zero.
        if (cb.rd) begin
            case (cb.addr)
                ADDR_TSC:  n.rdata = s.tsc;
                ADDR_THR:  n.rdata = s.thr;
                ADDR_SYMA: n.rdata = {3'h0, s.sym_a};
                ADDR_SYMB: n.rdata = {3'h0, s.sym_b};
                default:   n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= STATE_RESET;
        end else if (ce) begin
            s <= n;
        end
    end

    // ==========================================================================
    // Assertions.
    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_pair_tick;
        ce && tick && !stop_mode;
    endsequence

    sequence s_plain_tick;
        s_pair_tick ##0 (ic == IC_NONE);
    endsequence

    property p_reset_value;
        $rose(rst_b) |-> (s.tsc == TSC_RESET) && !s.tx.en;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset value");

    property p_idle;
        s_plain_tick ##0 (tm == TM_IDLE) |=> (tx.pair == tsi_mk_pair(SYM_IDLE, SYM_IDLE)) && tx.en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle pair wrong");

    property p_off;
        s_plain_tick ##0 (tm == TM_OFF) |=> (tx.pair == '0) && !tx.en && tx.strobe;
    endproperty
    a_off: assert property (p_off) else $error("off pair wrong");

    property p_master;
        s_plain_tick ##0 (tm == TM_MASTER) |=> tx.pair == tsi_mk_pair(SYM_HALT, SYM_QUIET);
    endproperty
    a_master: assert property (p_master) else $error("master pair wrong");

    property p_halt;
        s_plain_tick ##0 (tm == TM_HALT) |=> tx.pair == tsi_mk_pair(SYM_HALT, SYM_HALT);
    endproperty
    a_halt: assert property (p_halt) else $error("halt pair wrong");

    property p_forward;
        s_plain_tick ##0 ((tm == TM_ACTIVE) && fifo_valid) |=> tx.pair == $past(fifo_data);
    endproperty
    a_forward: assert property (p_forward) else $error("data not forwarded");

    property p_continuous;
        s_pair_tick ##0 (ic == IC_CONT) |=> tx.pair == tsi_mk_pair($past(s.sym_a), $past(s.sym_b));
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous pair wrong");

    property p_oneshot_jk;
        s_pair_tick ##0 ((ic == IC_ONESHOT) && (s.os == OS_WAIT) && is_jk && (s.thr == '0) && !tsc_wr)
            |=> (tx.pair == tsi_mk_pair($past(s.sym_a), $past(s.sym_b))) && !s.tsc[IC0_BIT];
    endproperty
    a_oneshot_jk: assert property (p_oneshot_jk) else $error("JK not replaced");

    property p_reject;
        ce && tsc_wr && s.copy_busy |=> cb_write_reject && (s.tsc[TM_MSB:TM_LSB] == $past(trigger_tx_mode))
            && ((s.tsc >> IC1_BIT) == ($past(s.tsc) >> IC1_BIT));
    endproperty
    a_reject: assert property (p_reject) else $error("write not rejected");

    property p_stop;
        ce && tick && stop_mode |=> (tx.pair == '0) && !tx.en;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mode output wrong");

    property p_thr_reload;
        ce && thr_wr |=> s.cnt == $past(cb.wdata);
    endproperty
    a_thr_reload: assert property (p_thr_reload) else $error("counter not reloaded");
endmodule

// [verification/tsi_mac_model.sv]
// Request data source and transmit pair monitor facing the injector.
`timescale 1ns/10ps

// ========================================
// Partner model.
module tsi_mac_model (
    input  wire logic             clk,
    input  wire logic             stall,
    input  wire logic             req_ready,
    input  wire tsi_pkg::tsi_tx_t tx,
    output logic                  req_valid,
    output tsi_pkg::tsi_pair_t    req_pair
);
    import tsi_pkg::*;
    tsi_pair_t q[$];
    tsi_pair_t last_pair = '0;
    logic      last_en   = 1'b0;
    int        strobes   = 0;

    initial begin
        req_valid = 1'b0;
        req_pair = '0;
    end

    // A pair is held until taken; an idle bus shows a changing pattern.
    always @(negedge clk) begin
        if (q.size() > 0 && (req_valid || !stall)) begin
            req_valid <= 1'b1;
            req_pair <= q[0];
        end else begin
            req_valid <= 1'b0;
            req_pair <= ~req_pair;
        end
    end

    always @(posedge clk) begin
        if (req_valid && req_ready) begin
            q.delete(0);
        end
        if (tx.strobe === 1'b1) begin
            last_pair <= tx.pair;
            last_en <= tx.en;
            strobes <= strobes + 1;
        end
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the transmit line state injector.
`timescale 1ns/10ps

// ========================================
// Bench top.
module testbench;
    import tsi_pkg::*;
    logic          clk        = 1'b0;
    logic          rst_b      = 1'b0;
    logic          stall      = 1'b0;
    logic          trig       = 1'b0;
    logic          trig_en    = 1'b0;
    logic [2:0]    trig_tm    = 3'h0;
    logic          stop       = 1'b0;
    logic          ce         = 1'b1;
    tsi_cbus_req_t cb         = '0;
    logic [7:0]    rdata;
    logic          reject;
    logic          req_valid;
    logic          req_ready;
    tsi_pair_t     req_pair;
    tsi_tx_t       tx;
    logic          se;
    logic          pe;
    int            seed       = 19545;
    int            fail_count = 0;
    int            checked    = 0;
    int            n;
    logic [7:0]    r;
    logic [7:0]    v;
    logic [4:0]    a;
    logic [4:0]    b;
    logic          en_exp;
    tsi_pair_t     pq[$];
    tsi_pair_t     eq[$];
    logic [2:0]    tms[8]     = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7, 3'h2, 3'h6};
    logic [1:0]    ics[4]     = '{2'h3, 2'h2, 2'h2, 2'h0};
    logic [7:0]    thrs[4]    = '{8'h05, 8'h00, 8'h03, 8'h00};
    localparam tsi_pair_t JK   = '{SYM_J, SYM_K};
    localparam tsi_pair_t IDLE = '{SYM_IDLE, SYM_IDLE};

    always #2.5 clk = ~clk;
    always @(negedge clk) stall <= ($random(seed) & 3) == 0;

    tsi_injector uut (
        .clk             (clk),
        .rst_b           (rst_b),
        .ce              (ce),
        .cb              (cb),
        .cb_rdata        (rdata),
        .cb_write_reject (reject),
        .req_valid       (req_valid),
        .req_pair        (req_pair),
        .req_ready       (req_ready),
        .trigger_pin     (trig),
        .trigger_react_en(trig_en),
        .trigger_tx_mode (trig_tm),
        .stop_mode       (stop),
        .tx              (tx),
        .smoother_en     (se),
        .req_parity_en   (pe)
    );

    tsi_mac_model mac (
        .clk      (clk),
        .stall    (stall),
        .req_ready(req_ready),
        .tx       (tx),
        .req_valid(req_valid),
        .req_pair (req_pair)
    );

    // ========================================
    // Tasks and expectations.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        cb = '{1'b1, 1'b0, ad, d};
        @(negedge clk);
        cb = '0;
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk);
        cb = '{1'b0, 1'b1, ad, 8'h00};
        @(negedge clk);
        cb = '0;
        check("register", rdata, exp);
    endtask

    task automatic wait_pairs(input int k);
        int t;
        t = mac.strobes + k;
        for (int i = 0; i < 40 * k && mac.strobes < t; i++) @(negedge clk);
    endtask

    task automatic stream(input tsi_pair_t skip);
        wait_pairs(1);
        for (int i = 0; i < 8 && mac.last_pair === skip; i++) wait_pairs(1);
        foreach (eq[i]) begin
            if (i > 0) wait_pairs(1);
            check("stream pair", mac.last_pair, eq[i]);
        end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    function automatic tsi_pair_t mode_pair(input logic [2:0] tm);
        case (tm)
            TM_IDLE:   mode_pair = '{SYM_IDLE, SYM_IDLE};
            TM_MASTER: mode_pair = '{SYM_HALT, SYM_QUIET};
            TM_HALT:   mode_pair = '{SYM_HALT, SYM_HALT};
            default:   mode_pair = '{SYM_QUIET, SYM_QUIET};
        endcase
    endfunction

    function automatic int inj_count(input logic [1:0] ic, input logic [7:0] thr);
        if (ic == IC_CONT || (ic == IC_PERIODIC && thr < 2)) return 6;
        return (ic == IC_PERIODIC) ? 6 / thr : 0;
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ========================================
    // Test sequence.
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        rdc(ADDR_TSC, TSC_RESET);
        rdc(ADDR_THR, 8'h00);
        wr(8'h20, 8'h55);
        rdc(8'h20, 8'h00);
        check("smoother", se, 1'b1);
        check("parity", pe, 1'b0);
        wait_pairs(2);
        check("off pair", mac.last_pair, 10'h000);
        check("off enable", mac.last_en, 1'b0);
        done("reset");
        en_exp = 1'b0;
        foreach (tms[i]) begin
            r = 8'($random(seed));
            v = {r[2:0], 2'b00, tms[i]};
            wr(ADDR_TSC, v);
            en_exp = (tms[i] == TM_OFF) ? 1'b0 : (tms[i][1] ? en_exp : 1'b1);
            wait_pairs(2);
            check("mode pair", mac.last_pair, mode_pair(tms[i]));
            check("mode enable", mac.last_en, en_exp);
            check("smoother", se, r[0]);
            check("parity", pe, r[1]);
            rdc(ADDR_TSC, v);
        end
        done("modes");
        repeat (9) pq.push_back(10'($random(seed)) | 10'h001);
        foreach (pq[i]) mac.q.push_back(pq[i]);
        repeat (40) @(negedge clk);
        check("ready when full", req_ready, 1'b0);
        check("left in source", mac.q.size(), 1);
        eq = pq;
        wr(ADDR_TSC, 8'ha0);
        stream(10'h000);
        wait_pairs(1);
        check("underrun", mac.last_pair, IDLE);
        check("active enable", mac.last_en, 1'b1);
        done("fifo");
        r = 8'($random(seed));
        a = {1'b0, r[3:0]} | 5'h01;
        b = r[7:3];
        wr(ADDR_SYMA, {3'b111, a});
        wr(ADDR_SYMB, {3'b111, b});
        rdc(ADDR_SYMA, {3'b000, a});
        rdc(ADDR_SYMB, {3'b000, b});
        foreach (ics[i]) begin
            wr(ADDR_THR, thrs[i]);
            wr(ADDR_TSC, {3'b101, ics[i], TM_IDLE});
            wait_pairs(2);
            n = 0;
            repeat (6) begin
                wait_pairs(1);
                n += (mac.last_pair === {a, b});
            end
            check("injected pairs", n, inj_count(ics[i], thrs[i]));
        end
        for (int t = 0; t < 4; t += 2) begin
            wr(ADDR_THR, 8'(t));
            wr(ADDR_TSC, 8'ha8);
            wait_pairs(2);
            pq = '{JK};
            repeat (3) pq.push_back(10'($random(seed)) & 10'h1ef);
            eq = pq;
            eq[t] = {a, b};
            foreach (pq[i]) mac.q.push_back(pq[i]);
            stream(IDLE);
            rdc(ADDR_TSC, 8'ha0);
        end
        done("injection");
        wr(ADDR_TSC, 8'ha1);
        stop = 1'b1;
        wait_pairs(2);
        check("stop pair", mac.last_pair, 10'h000);
        check("stop enable", mac.last_en, 1'b0);
        stop = 1'b0;
        wait_pairs(2);
        check("run pair", mac.last_pair, IDLE);
        ce = 1'b0;
        n = mac.strobes;
        wr(ADDR_TSC, 8'ha4);
        repeat (40) @(negedge clk);
        check("frozen pairs", mac.strobes - n, 0);
        ce = 1'b1;
        rdc(ADDR_TSC, 8'ha1);
        done("stop");
        trig_tm = TM_HALT;
        for (int k = 0; k < 2; k++) begin
            trig_en = 1'(k);
            trig = 1'b1;
            repeat (10) @(negedge clk);
            rdc(ADDR_TSC, (k == 1) ? 8'ha5 : 8'ha1);
            trig = 1'b0;
            repeat (10) @(negedge clk);
        end
        trig_tm = TM_MASTER;
        trig = 1'b1;
        n = 0;
        for (int j = 0; j < 14; j++) begin
            @(negedge clk);
            n += (reject === 1'b1);
            cb = (j < 12) ? '{1'b1, 1'b0, ADDR_TSC, 8'ha1} : '0;
        end
        check("refused writes", n, 2);
        done("trigger");
        finish_test;
    end

    // The sequence needs some 1400 cycles; the limit leaves wide margin.
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        finish_test;
    end
endmodule
